// ==== trvs_regs.vh ====
// Register offsets, fields, reset values and timing counts for the target row view block
`ifndef TRVS_REGS_VH
`define TRVS_REGS_VH
`define TRVS_ADDR_W        12
`define TRVS_REG_CMD       12'h000
`define TRVS_REG_STATUS    12'h004
`define TRVS_REG_IDLE      12'h008
`define TRVS_REG_PORTROW   12'h00c
`define TRVS_REG_LEDROW    12'h010
`define TRVS_REG_OUT       12'h014
`define TRVS_REG_WORD_LO   12'h018
`define TRVS_REG_WORD_HI   12'h01c
`define TRVS_REG_PANEL     12'h020
`define TRVS_CMD_OP_LSB    0
`define TRVS_CMD_OP_MSB    2
`define TRVS_CMD_ROW_LSB   4
`define TRVS_CMD_ROW_MSB   7
`define TRVS_CMD_HASROW    8
`define TRVS_CMD_KEEP      9
`define TRVS_CMD_BYNAME    10
`define TRVS_CMD_BIT_LSB   24
`define TRVS_CMD_BIT_MSB   30
`define TRVS_CMD_PORT_LSB  12
`define TRVS_CMD_PORT_MSB  13
`define TRVS_CMD_CNT_LSB   16
`define TRVS_CMD_CNT_MSB   23
`define TRVS_OP_VIEW       3'h1
`define TRVS_OP_FOLLOW     3'h2
`define TRVS_OP_RESET      3'h3
`define TRVS_OP_TIMEOUT    3'h4
`define TRVS_OP_QUIT       3'h5
`define TRVS_ROW_W         4
`define TRVS_NROWS         16
`define TRVS_NPORTS        4
`define TRVS_ROW_DEFAULT   4'h0
`define TRVS_LED_DEFAULT   4'h1
`define TRVS_IDLE_RESET    5'h05
`define TRVS_IDLE_MAX      5'h1e
`define TRVS_MINUTE_NS     36'd60000000000
`define TRVS_CLK_NS        10
`define TRVS_MINUTE_CYC    (`TRVS_MINUTE_NS / `TRVS_CLK_NS)
`endif

// ==== trvs_minute_tick.v ====
// Divider producing a one-cycle pulse per minute of ref_clk
`timescale 1ns/10ps
`include "trvs_regs.vh"
module trvs_minute_tick #(
    parameter [35:0] CYCLES = `TRVS_MINUTE_CYC
) (
    input  wire ref_clk,  // System clock
    input  wire sys_rst,  // Synchronous reset
    input  wire restart,  // Restart the minute
    output reg  tick      // One pulse per minute
);
    reg [35:0] count;

    always @(posedge ref_clk)
    begin
        if (sys_rst || restart)
        begin
            count <= 36'h0;
            tick  <= 1'b0;
        end
        else if (count == CYCLES - 36'h1)
        begin
            count <= 36'h0;
            tick  <= 1'b1;
        end
        else
        begin
            count <= count + 36'h1;
            tick  <= 1'b0;
        end
    end
endmodule

// ==== trvs_apb_slave.v ====
// APB register slave: decode, write strobes and read mux
`timescale 1ns/10ps
`include "trvs_regs.vh"
module trvs_apb_slave (
    input  wire        ref_clk,   // System clock
    input  wire        sys_rst,   // Synchronous reset
    input  wire        psel,      // APB select
    input  wire        penable,   // APB enable
    input  wire        pwrite,    // APB direction
    input  wire [11:0] paddr,     // APB byte address
    input  wire [31:0] pwdata,    // APB write data
    output reg  [31:0] prdata,    // APB read data
    output reg         pready,    // APB ready
    output reg         pslverr,   // APB error
    output wire        wr_stb,    // Write accepted this cycle
    output wire [11:0] wr_addr,   // Write address
    output wire [31:0] wr_data,   // Write data
    input  wire [31:0] rd_status, // Status word
    input  wire [31:0] rd_idle,   // Idle limit
    input  wire [31:0] rd_portrow,// Port rows
    input  wire [31:0] rd_ledrow, // LED row
    input  wire [31:0] rd_out,    // Display output
    input  wire [31:0] rd_word_lo,// Word rows 0..3
    input  wire [31:0] rd_word_hi // Word rows 4..7
);
    wire access = psel && penable && pready;
    reg  mapped;

    assign wr_stb  = access && pwrite;
    assign wr_addr = paddr;
    assign wr_data = pwdata;

    always @*
    begin
        case (paddr)
            `TRVS_REG_CMD, `TRVS_REG_STATUS, `TRVS_REG_IDLE, `TRVS_REG_PORTROW, `TRVS_REG_LEDROW,
            `TRVS_REG_OUT, `TRVS_REG_WORD_LO, `TRVS_REG_WORD_HI, `TRVS_REG_PANEL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // One wait state: ready rises in the second access cycle
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            // Writes return zero too, so an error response never carries stale data
            if (psel && penable && !pready && pwrite)
                prdata <= 32'h0;
            else if (psel && penable && !pready)
            begin
                case (paddr)
                    `TRVS_REG_STATUS:  prdata <= rd_status;
                    `TRVS_REG_IDLE:    prdata <= rd_idle;
                    `TRVS_REG_PORTROW: prdata <= rd_portrow;
                    `TRVS_REG_LEDROW:  prdata <= rd_ledrow;
                    `TRVS_REG_OUT:     prdata <= rd_out;
                    `TRVS_REG_WORD_LO: prdata <= rd_word_lo;
                    `TRVS_REG_WORD_HI: prdata <= rd_word_hi;
                    default:           prdata <= 32'h0;
                endcase
            end
        end
    end
endmodule

// ==== trvs_top.v ====
// Target row view selection: per-port default rows, row display and LED row remap
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "trvs_regs.vh"
module trvs_top #(
    parameter [35:0] MINUTE_CYCLES = `TRVS_MINUTE_CYC
) (
    input  wire        ref_clk,      // 100 MHz system clock
    input  wire        sys_rst,      // Synchronous reset, active high
    input  wire        psel,         // APB select
    input  wire        penable,      // APB enable
    input  wire        pwrite,       // APB direction
    input  wire [11:0] paddr,        // APB address
    input  wire [31:0] pwdata,       // APB write data
    output wire [31:0] prdata,       // APB read data
    output wire        pready,       // APB ready
    output wire        pslverr,      // APB error
    input  wire        panel_button, // Any front-panel button, pin
    input  wire        target_reset, // Target reset button, pin
    output reg  [7:0]  led_row2,     // Second LED row
    output reg  [7:0]  view_bits,    // Bits of the row being shown
    output reg  [3:0]  view_row,     // Row being shown
    output reg         view_valid    // One pulse per displayed copy
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SHOW = 2'h1;

    wire        wr_stb;
    wire [11:0] wr_addr;
    wire [31:0] wr_data;
    wire        minute_tick;

    reg  [1:0]  state;
    reg  [7:0]  repeat_left;
    reg  [3:0]  show_row;
    reg  [3:0]  port_row [0:`TRVS_NPORTS-1];
    reg  [3:0]  led_row;
    reg         led_remapped;
    reg  [4:0]  panel_idle_limit;
    reg  [4:0]  idle_minutes;
    reg  [7:0]  word_row [0:`TRVS_NROWS-1];
    reg  [7:0]  shown_count;
    reg         btn_meta;
    reg         btn_sync;
    reg         trst_meta;
    reg         trst_sync;
    reg         trst_prev;
    reg         idle_expired;

    wire cmd_wr = wr_stb && (wr_addr == `TRVS_REG_CMD);
    wire [2:0] cmd_op   = wr_data[`TRVS_CMD_OP_MSB:`TRVS_CMD_OP_LSB];
    wire [3:0] cmd_row  = wr_data[`TRVS_CMD_ROW_MSB:`TRVS_CMD_ROW_LSB];
    wire       cmd_has  = wr_data[`TRVS_CMD_HASROW];
    wire       cmd_keep = wr_data[`TRVS_CMD_KEEP];
    wire [1:0] cmd_port = wr_data[`TRVS_CMD_PORT_MSB:`TRVS_CMD_PORT_LSB];
    wire [7:0] cmd_cnt  = wr_data[`TRVS_CMD_CNT_MSB:`TRVS_CMD_CNT_LSB];
    wire       cmd_name = wr_data[`TRVS_CMD_BYNAME];
    wire [6:0] cmd_bit  = wr_data[`TRVS_CMD_BIT_MSB:`TRVS_CMD_BIT_LSB];
    // Eight bits to a row, so a bit's index over eight is its row
    wire [3:0] sel_row  = cmd_name ? cmd_bit[6:3] : cmd_row;
    // New commands are ignored while a display run is in progress
    wire cmd_go   = cmd_wr && (state == ST_IDLE);
    wire is_view  = cmd_go && ((cmd_op == `TRVS_OP_VIEW) || (cmd_op == `TRVS_OP_FOLLOW));
    wire is_fol   = cmd_go && (cmd_op == `TRVS_OP_FOLLOW);
    wire is_reset = cmd_go && (cmd_op == `TRVS_OP_RESET);
    wire [3:0] req_row = cmd_has ? sel_row : port_row[cmd_port];
    wire trst_edge = trst_sync && !trst_prev;

    trvs_apb_slave u_apb (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .wr_stb     (wr_stb),
        .wr_addr    (wr_addr),
        .wr_data    (wr_data),
        .rd_status  ({22'h0, led_remapped, state == ST_SHOW, shown_count}),
        .rd_idle    ({27'h0, panel_idle_limit}),
        .rd_portrow ({16'h0, port_row[3], port_row[2], port_row[1], port_row[0]}),
        .rd_ledrow  ({27'h0, led_remapped, led_row}),
        .rd_out     ({20'h0, view_row, view_bits}),
        .rd_word_lo ({word_row[3], word_row[2], word_row[1], word_row[0]}),
        .rd_word_hi ({word_row[7], word_row[6], word_row[5], word_row[4]})
    );

    trvs_minute_tick #(
        .CYCLES (MINUTE_CYCLES)
    ) u_tick (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .restart (btn_sync),
        .tick    (minute_tick)
    );

    // Pins pass two flops before use
    // Button acts as a level; the target reset acts on its rising edge
    // Edge detector starts at the pin's idle low level: no false press after reset
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            btn_meta  <= 1'b0;
            btn_sync  <= 1'b0;
            trst_meta <= 1'b0;
            trst_sync <= 1'b0;
            trst_prev <= 1'b0;
        end
        else
        begin
            btn_meta  <= panel_button;
            btn_sync  <= btn_meta;
            trst_meta <= target_reset;
            trst_sync <= trst_meta;
            trst_prev <= trst_sync;
        end
    end

    // Relay word rows written by software; rows 8 to 15 read as zero
    genvar gi;
    generate
        for (gi = 0; gi < `TRVS_NROWS; gi = gi + 1)
        begin : g_word
            always @(posedge ref_clk)
            begin
                if (sys_rst)
                    word_row[gi] <= 8'h0;
                else if (wr_stb && (gi < 4) && (wr_addr == `TRVS_REG_WORD_LO))
                    word_row[gi] <= wr_data[(gi%4)*8 +: 8];
                else if (wr_stb && (gi >= 4) && (gi < 8) && (wr_addr == `TRVS_REG_WORD_HI))
                    word_row[gi] <= wr_data[(gi%4)*8 +: 8];
            end
        end
    endgenerate

    // Per-port default rows; a clear outranks a pick in the same cycle
    // Stored rows change at the command edge, ahead of the first copy
    generate
        for (gi = 0; gi < `TRVS_NPORTS; gi = gi + 1)
        begin : g_port
            wire on_port   = cmd_go && (cmd_port == gi);
            wire leave_row = on_port && ((cmd_op == `TRVS_OP_TIMEOUT) || (cmd_op == `TRVS_OP_QUIT));
            wire clear_row = is_reset || leave_row;
            wire pick_row  = is_view && on_port && cmd_has && !cmd_keep;
            always @(posedge ref_clk)
            begin
                if (sys_rst)
                    port_row[gi] <= `TRVS_ROW_DEFAULT;
                else if (clear_row)
                    port_row[gi] <= `TRVS_ROW_DEFAULT;
                else if (pick_row)
                    port_row[gi] <= sel_row;
            end
        end
    endgenerate

    always @(posedge ref_clk)
    begin
        if (sys_rst)
            panel_idle_limit <= `TRVS_IDLE_RESET;
        // Only bits 4:0 count: thirty-one clamps to thirty, settings of 32 and above wrap
        else if (wr_stb && (wr_addr == `TRVS_REG_IDLE))
            panel_idle_limit <= (wr_data[4:0] > `TRVS_IDLE_MAX) ? `TRVS_IDLE_MAX : wr_data[4:0];
    end

    // Idle minute counter; any button level holds it at zero
    reg  [4:0]  next_idle_minutes;
    reg         next_idle_expired;

    always @*
    begin
        next_idle_minutes = idle_minutes;
        next_idle_expired = 1'b0;
        // A limit of zero never expires, so a remap then stays until a reset command or a target reset edge
        if (btn_sync)
            next_idle_minutes = 5'h0;
        else if (minute_tick && (panel_idle_limit != 5'h0))
        begin
            if ((idle_minutes + 5'h1) >= panel_idle_limit)
            begin
                next_idle_minutes = 5'h0;
                next_idle_expired = 1'b1;
            end
            else
                next_idle_minutes = idle_minutes + 5'h1;
        end
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            idle_minutes <= 5'h0;
            idle_expired <= 1'b0;
        end
        else
        begin
            idle_minutes <= next_idle_minutes;
            idle_expired <= next_idle_expired;
        end
    end

    // LED remap; a follow landing with a button edge or timeout still takes
    reg  [3:0]  next_led_row;
    reg         next_led_remapped;

    always @*
    begin
        next_led_row      = led_row;
        next_led_remapped = led_remapped;
        if (is_reset)
        begin
            next_led_row      = `TRVS_LED_DEFAULT;
            next_led_remapped = 1'b0;
        end
        else if (is_fol)
        begin
            next_led_row      = req_row;
            next_led_remapped = 1'b1;
        end
        // Button edge or panel timeout restores the standard set
        else if (trst_edge || idle_expired)
        begin
            next_led_row      = `TRVS_LED_DEFAULT;
            next_led_remapped = 1'b0;
        end
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            led_row      <= `TRVS_LED_DEFAULT;
            led_remapped <= 1'b0;
        end
        else
        begin
            led_row      <= next_led_row;
            led_remapped <= next_led_remapped;
        end
    end

    // LED row follows live bits of the mapped row; plain view never touches it
    // One cycle behind a remap, too short to see on the panel
    always @(posedge ref_clk)
    begin
        if (sys_rst)
            led_row2 <= 8'h0;
        else
            led_row2 <= word_row[led_row];
    end

    // Display sequencer: next-state logic apart from the registers
    reg  [1:0]  next_state;
    reg  [7:0]  next_repeat_left;
    reg  [3:0]  next_show_row;
    reg  [7:0]  next_shown_count;
    reg  [7:0]  next_view_bits;
    reg  [3:0]  next_view_row;
    reg         next_view_valid;

    always @*
    begin
        // Hold everything but the copy strobe
        next_state       = state;
        next_repeat_left = repeat_left;
        next_show_row    = show_row;
        next_shown_count = shown_count;
        next_view_bits   = view_bits;
        next_view_row    = view_row;
        next_view_valid  = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (is_view || is_reset)
                begin
                    // Reset command shows row 0 once
                    next_show_row    = is_reset ? `TRVS_ROW_DEFAULT : req_row;
                    next_repeat_left = (is_view && (cmd_cnt != 8'h0)) ? cmd_cnt : 8'h1;
                    next_shown_count = 8'h0;
                    next_state       = ST_SHOW;
                end
            end
            ST_SHOW:
            begin
                // Bits are sampled per copy, so repeats show live changes
                next_view_row    = show_row;
                next_view_bits   = word_row[show_row];
                next_view_valid  = 1'b1;
                next_shown_count = shown_count + 8'h1;
                next_repeat_left = repeat_left - 8'h1;
                if (repeat_left == 8'h1)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // Outputs are registered straight from the next-state logic
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state       <= ST_IDLE;
            repeat_left <= 8'h0;
            show_row    <= 4'h0;
            view_bits   <= 8'h0;
            view_row    <= 4'h0;
            view_valid  <= 1'b0;
            shown_count <= 8'h0;
        end
        else
        begin
            state       <= next_state;
            repeat_left <= next_repeat_left;
            show_row    <= next_show_row;
            shown_count <= next_shown_count;
            view_bits   <= next_view_bits;
            view_row    <= next_view_row;
            view_valid  <= next_view_valid;
        end
    end
endmodule

// ==== trvs_top_props.sv ====
// Port-level assertions for the target row view block
`timescale 1ns/10ps
`include "trvs_regs.vh"
module trvs_top_props #(
    parameter [35:0] MINUTE_CYCLES = 36'd20
) (
    input wire        ref_clk,    // Clock
    input wire        sys_rst,    // Reset
    input wire        psel,       // Select
    input wire        penable,    // Enable
    input wire        pwrite,     // Direction
    input wire [11:0] paddr,      // Address
    input wire [31:0] pwdata,     // Write data
    input wire [31:0] prdata,     // Read data
    input wire        pready,     // Ready
    input wire        pslverr,    // Error
    input wire [3:0]  view_row,   // Shown row
    input wire        view_valid  // Copy pulse
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    wire       cmd_wr = psel && penable && pready && pwrite && paddr == `TRVS_REG_CMD;
    wire [2:0] op     = pwdata[2:0];
    wire       shows  = op == `TRVS_OP_VIEW || op == `TRVS_OP_FOLLOW;
    wire [3:0] asked  = pwdata[10] ? pwdata[30:27] : pwdata[7:4];
    sequence one_copy;
        !view_valid ##1 view_valid ##1 !view_valid;
    endsequence
    sequence two_copies;
        !view_valid ##1 view_valid [*2] ##1 !view_valid;
    endsequence
    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held");
    unmapped_err_a: assert property (psel && penable && !pready && paddr > `TRVS_REG_PANEL |=> pslverr)
        else $error("no error on unmapped address");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error response");
    single_copy_a: assert property (cmd_wr && shows && pwdata[23:16] == 8'h00 |=> one_copy)
        else $error("single copy wrong");
    double_copy_a: assert property (cmd_wr && shows && pwdata[23:16] == 8'h02 |=> two_copies)
        else $error("double copy wrong");
    shown_row_a: assert property (cmd_wr && shows && pwdata[8] |-> ##2 view_row == $past(asked, 2))
        else $error("shown row differs from request");
    reset_show_a: assert property (cmd_wr && op == `TRVS_OP_RESET |-> ##2 view_valid && view_row == 4'h0)
        else $error("reset did not show row 0");
endmodule
bind trvs_top trvs_top_props #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_props (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .view_row(view_row), .view_valid(view_valid));

// ==== trvs_term.sv ====
// Terminal-side model issuing register transfers to the block
`timescale 1ns/10ps
module trvs_term (
    input  wire         ref_clk, // Clock
    output logic        psel,    // Select
    output logic        penable, // Enable
    output logic        pwrite,  // Direction
    output logic [11:0] paddr,   // Address
    output logic [31:0] pwdata,  // Write data
    input  wire  [31:0] prdata,  // Read data
    input  wire         pready,  // Ready
    input  wire         pslverr  // Error
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'hfff;
        pwdata = 32'h0;
    end
    // Entered just after an edge; the idle edge at the end keeps calls apart
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge ref_clk);
            penable <= 1'b1;
            @(posedge ref_clk);
            while (pready !== 1'b1)
                @(posedge ref_clk);
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // Released lines must not keep looking valid
            paddr <= ~a;
            pwdata <= ~d;
            @(posedge ref_clk);
        end
    endtask
endmodule

// ==== tb_target_row_view_select.sv ====
// Self-checking bench for the target row view block
`timescale 1ns/10ps
`include "trvs_regs.vh"
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module tb_target_row_view_select;
    logic        ref_clk, sys_rst, panel_button, target_reset, rerr, rem;
    wire         psel, penable, pwrite, pready, pslverr, view_valid;
    wire  [11:0] paddr;
    wire  [31:0] pwdata, prdata;
    wire  [7:0]  led_row2, view_bits;
    wire  [3:0]  view_row;
    int          num_errors, n_checks, cyc, nv;
    logic [31:0] seed, rdat;
    logic [7:0]  wrow [0:15];
    logic [7:0]  lbits;
    logic [3:0]  prow [0:3];
    logic [3:0]  led, lrow;
    trvs_top #(.MINUTE_CYCLES(36'd20)) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .panel_button(panel_button), .target_reset(target_reset), .led_row2(led_row2),
        .view_bits(view_bits), .view_row(view_row), .view_valid(view_valid));
    trvs_term term (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (view_valid === 1'b1)
        begin
            nv++;
            lrow = view_row;
            lbits = view_bits;
        end
        if (cyc > 20000)
        begin
            num_errors++;
            finish_test();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] copies(input logic [2:0] op, input logic [7:0] cnt);
        if (op == `TRVS_OP_VIEW || op == `TRVS_OP_FOLLOW)
            return (cnt == 8'h00) ? 8'h01 : cnt;
        return (op == `TRVS_OP_RESET) ? 8'h01 : 8'h00;
    endfunction
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        term.xfer(w, a, d, rdat, rerr);
    endtask
    task chk_rd(input logic [11:0] a, input logic [31:0] e);
        begin
            acc(1'b0, a, 32'h0);
            `CHK("read", e, rdat)
        end
    endtask
    task cmd(input logic [2:0] op, input logic [3:0] row, input logic hr, input logic kp, input logic [1:0] pt,
             input logic [7:0] cnt);
        logic [3:0] shown;
        begin
            shown = (op == `TRVS_OP_RESET) ? 4'h0 : (hr ? row : prow[pt]);
            nv = 0;
            acc(1'b1, `TRVS_REG_CMD, {8'h00, cnt, 2'b00, pt, 2'b00, kp, hr, row, 1'b0, op});
            repeat (int'(cnt) + 6) @(posedge ref_clk);
            `CHK("copies", copies(op, cnt), nv[7:0])
            if (copies(op, cnt) != 8'h00)
            begin
                `CHK("row", shown, lrow)
                `CHK("bits", wrow[shown], lbits)
            end
            if (op == `TRVS_OP_VIEW || op == `TRVS_OP_FOLLOW)
            begin
                if (hr && !kp)
                    prow[pt] = row;
                if (op == `TRVS_OP_FOLLOW)
                begin
                    led = shown;
                    rem = 1'b1;
                end
            end
            else if (op == `TRVS_OP_RESET)
            begin
                prow = '{default: 4'h0};
                led = 4'h1;
                rem = 1'b0;
            end
            else
                prow[pt] = 4'h0;
            if (copies(op, cnt) != 8'h00)
            begin
                chk_rd(`TRVS_REG_STATUS, {22'h0, rem, 1'b0, copies(op, cnt)});
                chk_rd(`TRVS_REG_OUT, {20'h0, shown, wrow[shown]});
            end
            chk_rd(`TRVS_REG_PORTROW, {16'h0, prow[3], prow[2], prow[1], prow[0]});
            chk_rd(`TRVS_REG_LEDROW, {27'h0, rem, led});
            `CHK("led", wrow[led], led_row2)
        end
    endtask
    task finish_test;
        begin
            if (num_errors == 0 && n_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial
    begin
        sys_rst = 1'b1;
        panel_button = 1'b0;
        target_reset = 1'b0;
        seed = 32'd81759;
        led = 4'h1;
        rem = 1'b0;
        prow = '{default: 4'h0};
        for (int r = 0; r < 16; r++)
            wrow[r] = 8'h00;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk_rd(`TRVS_REG_IDLE, 32'h5);
        chk_rd(`TRVS_REG_LEDROW, 32'h1);
        // Idle timeout off so remaps cannot revert mid-test
        acc(1'b1, `TRVS_REG_IDLE, 32'h0);
        acc(1'b0, 12'h040, 32'h0);
        `CHK("unmapped", 1'b1, rerr)
        for (int i = 0; i < 2; i++)
        begin
            seed = lfsr(seed);
            acc(1'b1, (i == 0) ? `TRVS_REG_WORD_LO : `TRVS_REG_WORD_HI, seed);
            for (int b = 0; b < 4; b++)
                wrow[4 * i + b] = seed[8 * b +: 8];
            chk_rd((i == 0) ? `TRVS_REG_WORD_LO : `TRVS_REG_WORD_HI, seed);
        end
        cmd(`TRVS_OP_VIEW, 4'h5, 1'b1, 1'b0, 2'd0, 8'h00);
        cmd(`TRVS_OP_VIEW, 4'h0, 1'b0, 1'b0, 2'd0, 8'h02);
        cmd(`TRVS_OP_VIEW, 4'h6, 1'b1, 1'b1, 2'd1, 8'h00);
        cmd(`TRVS_OP_FOLLOW, 4'h3, 1'b1, 1'b0, 2'd2, 8'h00);
        cmd(`TRVS_OP_FOLLOW, 4'h7, 1'b1, 1'b1, 2'd3, 8'h01);
        cmd(`TRVS_OP_VIEW, 4'h0, 1'b1, 1'b0, 2'd2, 8'hff);
        // Bit 51 lies in row 6; port 3 takes that row as its default
        acc(1'b1, `TRVS_REG_CMD, 32'h33003501);
        repeat (6) @(posedge ref_clk);
        prow[3] = 4'h6;
        `CHK("named row", 4'h6, lrow)
        chk_rd(`TRVS_REG_PORTROW, {16'h0, prow[3], prow[2], prow[1], prow[0]});
        for (int i = 0; i < 40; i++)
        begin
            seed = lfsr(seed);
            panel_button <= seed[20];
            cmd(3'(seed[2:0] % 5 + 1), seed[7:4], seed[8], seed[9], seed[13:12], {6'h0, seed[17:16]});
        end
        panel_button <= 1'b0;
        acc(1'b1, `TRVS_REG_IDLE, 32'h1f);
        chk_rd(`TRVS_REG_IDLE, 32'h1e);
        acc(1'b1, `TRVS_REG_IDLE, 32'h0);
        cmd(`TRVS_OP_FOLLOW, 4'h2, 1'b1, 1'b0, 2'd0, 8'h00);
        repeat (120) @(posedge ref_clk);
        chk_rd(`TRVS_REG_LEDROW, 32'h12);
        acc(1'b1, `TRVS_REG_IDLE, 32'h1);
        repeat (100) @(posedge ref_clk);
        chk_rd(`TRVS_REG_LEDROW, 32'h1);
        `CHK("led", wrow[1], led_row2)
        acc(1'b1, `TRVS_REG_IDLE, 32'h0);
        cmd(`TRVS_OP_FOLLOW, 4'h4, 1'b1, 1'b0, 2'd1, 8'h00);
        target_reset <= 1'b1;
        repeat (4) @(posedge ref_clk);
        target_reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk_rd(`TRVS_REG_LEDROW, 32'h1);
        finish_test();
    end
endmodule
